// ### common/ppfs_defs.vh
// Notes on behaviour
// - Six-bit function select, zero means high impedance
// - Each pin register has interrupt-input select bit
// - Select clear: pin never reaches interrupt line
// - Select set: pin level drives its line
// - Port B pin 1 drives interrupt line 4
// - Port B pin 6 drives interrupt line 2
// - Port D pins 0-5 have own registers
`ifndef PPFS_DEFS_VH
`define PPFS_DEFS_VH

// Register byte offsets, one aligned word per pin
`define PPFS_OFS_PORTB1   8'h00
`define PPFS_OFS_PORTB6   8'h04
`define PPFS_OFS_PB7      8'h08
`define PPFS_OFS_PD0      8'h0C
`define PPFS_OFS_PD1      8'h10
`define PPFS_OFS_PD2      8'h14
`define PPFS_OFS_PD3      8'h18
`define PPFS_OFS_PD4      8'h1C
`define PPFS_OFS_PD5      8'h20
`define PPFS_OFS_STATUS   8'h24

// Field layout of a pin control register
`define PPFS_SEL_MSB      5
`define PPFS_SEL_LSB      0
`define PPFS_INTSEL_BIT   6
`define PPFS_REG_RESET    8'h00
`define PPFS_CODE_HIZ     6'h00

// Pin indices inside the pin vector
`define PPFS_NPINS        9
`define PPFS_IDX_PORTB1   0
`define PPFS_IDX_PORTB6   1

// Interrupt line numbers reached by the pins
`define PPFS_NLINES       16
`define PPFS_LINE_PORTB1  4
`define PPFS_LINE_PORTB6  2

// AXI responses
`define PPFS_RESP_OKAY    2'h0
`define PPFS_RESP_SLVERR  2'h2

`endif

// ### hw/ppfs_pin_slice.v
`timescale 1ns/100ps
`include "ppfs_defs.vh"

// One pin: decode of the function select and of the interrupt select.
module ppfs_pin_slice #(
    parameter                NSIG = 64,      // Peripheral signals selectable
    parameter [NSIG-1:0]     VALID_MASK = {NSIG{1'b1}} // Codes assigned to this pin
) (
    input  wire [7:0]        ctrl,           // Pin control register
    input  wire [NSIG-1:0]   periph_out,     // Output of each selectable peripheral
    input  wire [NSIG-1:0]   periph_oe,      // Drive request of each peripheral
    input  wire              pin_in,         // Level seen on the pin
    output reg               pad_out,        // Value to drive
    output reg               pad_oe,         // Drive enable
    output reg               irq_level       // Level offered to the interrupt line
);

    wire [5:0] sel_code = ctrl[`PPFS_SEL_MSB:`PPFS_SEL_LSB]; // Function code

    // Route exactly one peripheral; zero and reserved codes leave the pin undriven
    always @* begin
        pad_out = 1'b0;
        pad_oe  = 1'b0;
        if (sel_code != `PPFS_CODE_HIZ && VALID_MASK[sel_code]) begin
            pad_out = periph_out[sel_code];
            pad_oe  = periph_oe[sel_code];
        end
    end

    // Forward the pin level only while interrupt select is set
    always @* begin
        if (ctrl[`PPFS_INTSEL_BIT]) begin
            irq_level = pin_in;
        end else begin
            irq_level = 1'b0;
        end
    end

endmodule // ppfs_pin_slice

// ### hw/ppfs_top.v
`timescale 1ns/100ps
`include "ppfs_defs.vh"

// Pin function select block for port B pins 1,6,7 and port D pins 0-5.
module ppfs_top #(
    parameter                   NSIG = 64    // Peripheral signals per pin
) (
    input  wire                 aclk,
    input  wire                 aresetn,
    input  wire                 clk_en,
    // AXI4-Lite write address
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Pins, index order: port B pins 1, 6, 7, then port D pins 0 to 5
    input  wire [`PPFS_NPINS*NSIG-1:0] periph_out,
    input  wire [`PPFS_NPINS*NSIG-1:0] periph_oe,
    input  wire [`PPFS_NPINS-1:0]      pin_in,
    output reg  [`PPFS_NPINS-1:0]      pin_out,
    output reg  [`PPFS_NPINS-1:0]      pin_oe,
    output reg  [`PPFS_NLINES-1:0]     ext_irq_line
);

    // Overview of the block
    //
    // Nine pin control registers sit behind a small register bus slave.
    // Each register is one byte inside an aligned 32-bit word:
    //   bits 5..0  function code, zero leaves the pad undriven
    //   bit  6     interrupt select, hands the pad level to a line
    //   bit  7     not stored, always reads as zero
    // Bits 31..8 of every pin word read as zero and ignore writes.
    //
    // The pad side is purely a decode of the stored byte. Each pin has
    // its own slice, so the decode of one pin can never disturb another.
    // The decoded values pass through one register stage on their way
    // out, which keeps every top-level output straight from a flop and
    // costs one cycle of latency after a register write lands.
    //
    // Only two pins have an interrupt line of their own. The select bit
    // of the other seven pins is stored and reads back, but it reaches
    // nothing; software may still use it as a spare flag.
    //
    // The status word mirrors the pad enables. It is read-only, and a
    // write to it is refused with an error response so that a driver
    // bug shows up instead of being swallowed.
    //
    // The clock enable freezes everything, the bus included. A master
    // that keeps its valid high while the enable is low simply waits;
    // no handshake is lost, because the ready pulses freeze as well.
    //
    // Reset is synchronous and wins over the clock enable, so the block
    // can be reset while it is otherwise stopped.
    //
    // Hazard: a reserved function code is not refused on the bus. It is
    // stored as written, and with VALID_MASK left at all ones the slice routes it like any other code.

    // Write channel states, one-hot
    localparam [2:0] WS_IDLE = 3'b001;
    localparam [2:0] WS_ADDR = 3'b010;       // Holding address, waiting for data
    localparam [2:0] WS_RESP = 3'b100;

    reg  [7:0]                  ctrl_ff [0:`PPFS_NPINS-1]; // Pin control registers
    reg  [2:0]                  wst_ff;      // Write state
    reg  [7:0]                  awaddr_ff;   // Latched write address
    reg                         wgot_ff;     // Write data held in the data latch
    reg  [31:0]                 wdata_ff;    // Latched write data
    reg  [3:0]                  wstrb_ff;    // Latched strobes
    wire [`PPFS_NPINS-1:0]      nxt_out;     // Decoded pad values
    wire [`PPFS_NPINS-1:0]      nxt_oe;      // Decoded pad enables
    wire [`PPFS_NPINS-1:0]      irq_lvl;     // Gated pin levels
    reg  [`PPFS_NLINES-1:0]     nxt_irq;     // Interrupt line map
    reg  [3:0]                  idx;         // Decoded register index
    reg                         hit;         // Address maps to a register

    // Address decode to a pin index; status word is read-only
    function [4:0] dec;
        input [7:0] a;
        begin
            case (a)
                `PPFS_OFS_PORTB1: dec = {1'b1, 4'd0};
                `PPFS_OFS_PORTB6: dec = {1'b1, 4'd1};
                `PPFS_OFS_PB7: dec = {1'b1, 4'd2};
                `PPFS_OFS_PD0: dec = {1'b1, 4'd3};
                `PPFS_OFS_PD1: dec = {1'b1, 4'd4};
                `PPFS_OFS_PD2: dec = {1'b1, 4'd5};
                `PPFS_OFS_PD3: dec = {1'b1, 4'd6};
                `PPFS_OFS_PD4: dec = {1'b1, 4'd7};
                `PPFS_OFS_PD5: dec = {1'b1, 4'd8};
                default:       dec = 5'h00;
            endcase
        end
    endfunction

    // One decode slice per pin
    genvar g;
    generate
        for (g = 0; g < `PPFS_NPINS; g = g + 1) begin : g_pin
            ppfs_pin_slice #(
                .NSIG       (NSIG)
            ) u_slice (
                .ctrl       (ctrl_ff[g]),
                .periph_out (periph_out[g*NSIG +: NSIG]),
                .periph_oe  (periph_oe[g*NSIG +: NSIG]),
                .pin_in     (pin_in[g]),
                .pad_out    (nxt_out[g]),
                .pad_oe     (nxt_oe[g]),
                .irq_level  (irq_lvl[g])
            );
        end
    endgenerate

    // Only pins with a documented line reach the interrupt controller
    always @* begin
        nxt_irq = {`PPFS_NLINES{1'b0}};
        nxt_irq[`PPFS_LINE_PORTB1] = irq_lvl[`PPFS_IDX_PORTB1];
        nxt_irq[`PPFS_LINE_PORTB6] = irq_lvl[`PPFS_IDX_PORTB6];
    end

    // Registered pad and interrupt outputs; one cycle behind the register
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_out      <= {`PPFS_NPINS{1'b0}};
            pin_oe       <= {`PPFS_NPINS{1'b0}};
            ext_irq_line <= {`PPFS_NLINES{1'b0}};
        end else if (clk_en) begin
            pin_out      <= nxt_out;
            pin_oe       <= nxt_oe;
            ext_irq_line <= nxt_irq;
        end
    end

    // Decode of the latched write address
    always @* begin
        {hit, idx} = dec(awaddr_ff);
    end

    // Write channel: address and data in either order, then response
    //
    // Timing seen by a master that offers both together:
    //   edge 0  both valids seen, both readies raised
    //   edge 1  both handshakes complete, register written
    //   edge 2  response valid stands until the master takes it
    // Data that arrives alone is held in the data latch until the
    // address follows; an address that arrives alone waits in the
    // address state for its data. Either way the register is written
    // exactly once, in the cycle after both halves are held.
    //
    // The address is latched on the edge at which awready is raised,
    // one edge before the handshake completes. The master must hold
    // its address until the handshake anyway, so the value is the same.
    //
    // Only byte lane 0 carries a register; a write with that strobe low
    // leaves the register alone but still answers with success.
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            wst_ff        <= WS_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PPFS_RESP_OKAY;
            awaddr_ff     <= 8'h00;
            wgot_ff       <= 1'b0;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            for (i = 0; i < `PPFS_NPINS; i = i + 1) begin
                ctrl_ff[i] <= `PPFS_REG_RESET;
            end
        end else if (clk_en) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            case (wst_ff)
                WS_IDLE: begin
                    // Take data early, whether it arrives alone or with the address
                    if (s_axi_wvalid && !wgot_ff && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                        wdata_ff     <= s_axi_wdata;
                        wstrb_ff     <= s_axi_wstrb;
                        wgot_ff      <= 1'b1;
                    end
                    if (s_axi_awvalid && !s_axi_awready) begin
                        s_axi_awready <= 1'b1;
                        awaddr_ff     <= s_axi_awaddr;
                        wst_ff        <= WS_ADDR;
                    end
                end
                WS_ADDR: begin
                    if (wgot_ff) begin
                        // Byte lane 0 holds the whole register
                        if (hit && wstrb_ff[0]) begin
                            ctrl_ff[idx] <= {1'b0, wdata_ff[6:0]};
                        end
                        s_axi_bresp  <= hit ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
                        s_axi_bvalid <= 1'b1;
                        wgot_ff      <= 1'b0;
                        wst_ff       <= WS_RESP;
                    end else if (s_axi_wvalid && !s_axi_wready) begin
                        s_axi_wready <= 1'b1;
                        wdata_ff     <= s_axi_wdata;
                        wstrb_ff     <= s_axi_wstrb;
                        wgot_ff      <= 1'b1;
                    end
                end
                WS_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wst_ff       <= WS_IDLE;
                    end
                end
                default: begin
                    wst_ff <= WS_IDLE;
                end
            endcase
        end
    end

    // Read channel: arready and rvalid raised together, data in the same cycle
    //
    // The read data is captured together with arready, so rvalid rises
    // at the edge that raises arready, one edge before the address handshake completes. A new address is
    // not looked at while an answer stands, which limits the slave to
    // one read at a time. That trade keeps the channel to two flops of
    // state and no queue, at the cost of throughput nobody needs here.
    reg  [4:0] rdec;                         // Read address decode
    reg  [31:0] rword;                       // Read value
    always @* begin
        rdec  = dec(s_axi_araddr);
        rword = 32'h0000_0000;
        if (rdec[4]) begin
            rword = {24'h00_0000, ctrl_ff[rdec[3:0]]};
        end else if (s_axi_araddr == `PPFS_OFS_STATUS) begin
            // Status shows the live pad enables, the block's own state
            rword = {23'h00_0000, pin_oe};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PPFS_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rword;
                s_axi_rresp   <= (rdec[4] || s_axi_araddr == `PPFS_OFS_STATUS) ?
                                 `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
            end
        end
    end

endmodule // ppfs_top

// ### verification/ppfs_chk_sva.sv
`timescale 1ns/100ps
`include "ppfs_defs.vh"

// Bus handshakes and interrupt routing as seen at the top ports
module ppfs_chk (
    input logic        aclk,
    input logic        aresetn,
    input logic        clk_en,
    input logic        s_axi_awready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [8:0]  pin_in,
    input logic [15:0] ext_irq_line
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset must clear every answer and line by the next edge
    reset_quiet_a: assert property (disable iff (1'b0) !aresetn && clk_en |=>
        !s_axi_bvalid && !s_axi_rvalid && ext_irq_line == 16'h0000) else $error("reset not quiet");
    // Only lines 4 and 2 are ever reached
    other_lines_a: assert property ((ext_irq_line & 16'hFFEB) == 16'h0000)
        else $error("unrouted interrupt line active");
    pb1_low_a: assert property (clk_en && $past(clk_en) && !pin_in[0] && !$past(pin_in[0])
        |-> !ext_irq_line[`PPFS_LINE_PORTB1]) else $error("line 4 high with pin low");
    pb6_low_a: assert property (clk_en && $past(clk_en) && !pin_in[1] && !$past(pin_in[1])
        |-> !ext_irq_line[`PPFS_LINE_PORTB6]) else $error("line 2 high with pin low");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready && clk_en |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready && clk_en |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    aw_pulse_a: assert property (s_axi_awready && clk_en |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    ar_rvalid_a: assert property (s_axi_arready |-> s_axi_rvalid) else $error("rvalid late");
    slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `PPFS_RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000) else $error("refused read not zero");
endmodule // ppfs_chk

bind ppfs_top ppfs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_in(pin_in), .ext_irq_line(ext_irq_line));

// ### verification/tb_port_pin_function_select.sv
`timescale 1ns/100ps
`include "ppfs_defs.vh"

module tb_port_pin_function_select;
    logic         aclk = 0, aresetn = 0, clk_en = 1;
    logic [7:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
    logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic         s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0]  s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]   s_axi_wstrb = 0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    // Odd codes drive 1, every code requests drive, so code 0 alone shows Hi-Z
    logic [575:0] periph_out = {9{64'hAAAA_AAAA_AAAA_AAAA}}, periph_oe = '1;
    logic [8:0]   pin_in = 0, pin_out, pin_oe;
    logic [15:0]  ext_irq_line;
    int           n_fail = 0, checks_done = 0;
    // One row per pin, register order; bit 7 set in one row must read back 0
    logic [7:0]   row_wr [0:8] = '{8'h41, 8'h7F, 8'hAA, 8'h01, 8'h3E, 8'h15, 8'h00, 8'h3F, 8'h40};

    ppfs_top #(.NSIG(64)) u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_out(periph_out),
        .periph_oe(periph_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_irq_line(ext_irq_line));

    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic give_verdict;
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address and data offered together; bready comes late so bvalid must stand
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic pa, pw;
        pa = 1; pw = 1;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (pa && s_axi_awready) begin pa = 0; s_axi_awvalid <= 0; end
            if (pw && s_axi_wready) begin pw = 0; s_axi_wvalid <= 0; end
        end while (pa || pw);
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    // Late rready keeps rvalid and rdata standing for three cycles
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata; rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int i = 0; i < 9; i++) begin
            axi_wr(8'(4 * i), {24'h0, row_wr[i]}, 4'hF);
            check("write resp", rsp, `PPFS_RESP_OKAY);
        end
        for (int i = 0; i < 9; i++) begin
            axi_rd(8'(4 * i));
            check("readback", rd, {24'h0, row_wr[i] & 8'h7F});
        end
        check("pin enables", pin_oe, 9'h0BF);
        check("pin values", pin_out & pin_oe, 9'h0AB);
        pin_in <= 9'h1FF;
        repeat (3) @(posedge aclk);
        check("lines all high", ext_irq_line, 16'h0014);
        pin_in <= 9'h1FE;
        repeat (3) @(posedge aclk);
        check("line 4 follows", ext_irq_line, 16'h0004);
        axi_wr(`PPFS_OFS_PORTB1, 32'h01, 4'hF);
        pin_in <= 9'h1FF;
        repeat (3) @(posedge aclk);
        check("select cleared", ext_irq_line, 16'h0004);
        // Refusals: unmapped place, read-only status; then an empty strobe that leaves the register alone
        axi_wr(8'h28, 32'h3F, 4'hF);
        check("unmapped write", rsp, `PPFS_RESP_SLVERR);
        axi_rd(8'h28);
        check("unmapped read", {rd[29:0], rsp}, {30'h0, `PPFS_RESP_SLVERR});
        axi_wr(`PPFS_OFS_STATUS, 32'h0, 4'hF);
        check("status write", rsp, `PPFS_RESP_SLVERR);
        axi_wr(`PPFS_OFS_PORTB6, 32'h0, 4'h0);
        axi_rd(`PPFS_OFS_PORTB6);
        check("no strobe", rd, 32'h7F);
        // Clock enable low freezes the lines although the pin changes
        clk_en <= 0;
        pin_in <= 9'h1FD;
        repeat (3) @(posedge aclk);
        check("frozen line", ext_irq_line, 16'h0004);
        clk_en <= 1;
        repeat (3) @(posedge aclk);
        check("line 2 follows", ext_irq_line, 16'h0000);
        // Reset in mid-run returns every pin to Hi-Z
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        check("reset enables", {ext_irq_line, 7'h0, pin_oe}, 32'h0);
        axi_rd(`PPFS_OFS_PORTB6);
        check("reset value", rd, {24'h0, `PPFS_REG_RESET});
        give_verdict;
    end

    // A hung handshake ends the run as a failure
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        give_verdict;
    end
endmodule // tb_port_pin_function_select
